//--- incexec_core.sv
// Decode and execute slice: increments, OR forms, long call, moves, bank loads
`timescale 1ns/100ps
// Overview of operation
// - Opcode 0001 010d adds one to the file byte and updates overflow, carry, digit carry, zero.
// - The destination bit clear sends the result to the working register, set to the file.
// - Opcode 0001 111d increments with no flag change and skips when the result is zero.
// - Opcode 0010 010d increments with no flag change and skips when the result is nonzero.
// - A taken skip throws away the fetched word and spends one no-operation cycle.
// - Opcode 1011 0011 ORs a literal into the working register and updates zero.
// - Opcode 0000 100d ORs working register with the file byte, result per destination, zero only.
// - The long call first pushes the incremented program counter on the return stack.
// - The long call target is the holding latch as high byte and the literal as low byte.
// - The long call reaches all of 64K, lasts two cycles with a no-operation and keeps flags.
// - Opcode 011p pppp copies a file byte to a peripheral address 00h-1Fh, flags untouched.
// - The 8-bit file field reaches every byte of the 256-byte data space, save 0Ah as a move source, which reads the working register.
// - Either move operand may be the working register, at file or peripheral address 0Ah.
// - Opcode 1011 1000 loads a 4-bit literal into the low bank nibble only.
// - Opcode 1011 101x loads a 4-bit literal into the high bank nibble, x ignored.
// - The high nibble load keeps the low nibble and completes in one cycle.
module incexec_core
    import incexec_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // Instruction word, sampled at the end of the write phase, before each cycle
    input  wire logic [15:0] I_INSTR,
    // Data space read port, data returned same cycle
    output logic      [7:0]  O_RD_ADDR,
    input  wire logic [7:0]  I_RD_DATA,
    // Data space write port
    output logic             O_WR_EN,
    output logic      [7:0]  O_WR_ADDR,
    output logic      [7:0]  O_WR_DATA,
    // Return stack push and pc high holding latch
    output logic             O_PUSH_EN,
    output logic      [15:0] O_PUSH_DATA,
    input  wire logic [7:0]  I_PC_LATCH,
    // Status flags from and to the flag register
    input  wire logic [3:0]  I_FLAGS,
    output logic      [3:0]  O_FLAGS,
    // Core state
    output logic      [7:0]  O_WORKING_REGISTER,
    output logic      [7:0]  O_BANK,
    output logic      [15:0] O_PC,
    output logic      [1:0]  O_PHASE,
    output logic             O_NOP_CYCLE
);
    phase_t      phase_ff;
    logic [15:0] instr_ff;
    logic [7:0]  operand_ff;
    logic [8:0]  result_ff;
    logic [7:0]  working_register_ff;
    logic [7:0]  bank_ff;
    logic [15:0] pc_ff;
    logic [3:0]  flags_ff;
    logic        nop_ff;
    logic        nop_next_ff;
    logic        wr_en_ff;
    logic [7:0]  wr_addr_ff;
    logic [7:0]  wr_data_ff;
    logic        push_ff;
    logic [15:0] push_data_ff;

    logic        is_inc;
    logic        is_inc_sz;
    logic        is_inc_snz;
    logic        is_or_f;
    logic        is_or_l;
    logic        is_call;
    logic        is_bank_lo;
    logic        is_bank_hi;
    logic        is_move;
    logic        dest_file;
    logic [7:0]  file_addr;
    logic [7:0]  res8;
    logic [7:0]  inc_in;

    // Decode from the latched word; a nop cycle decodes as nothing
    always_comb begin
        is_inc     = !nop_ff && instr_ff[15:9] == OPC_INC_FILE;
        is_inc_sz  = !nop_ff && instr_ff[15:9] == OPC_INC_SKIP_Z;
        is_inc_snz = !nop_ff && instr_ff[15:9] == OPC_INC_SKIP_NZ;
        is_or_f    = !nop_ff && instr_ff[15:9] == OPC_OR_FILE;
        is_or_l    = !nop_ff && instr_ff[15:8] == OPC_OR_LITERAL;
        is_call    = !nop_ff && instr_ff[15:8] == OPC_LONG_CALL;
        is_bank_lo = !nop_ff && instr_ff[15:8] == OPC_BANK_LOW;
        is_bank_hi = !nop_ff && instr_ff[15:9] == OPC_BANK_HIGH;
        is_move    = !nop_ff && instr_ff[15:13] == OPC_MOVE_PERIPH;
        dest_file  = instr_ff[8];
        file_addr  = instr_ff[7:0];
        res8       = result_ff[7:0];
        inc_in     = operand_ff;
    end

    // Four phase sequencer
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            phase_ff <= PH_DECODE;
        end else begin
            phase_ff <= phase_t'(phase_ff + 2'd1);
        end
    end

    // Latch instruction and the skip/call filler decision at the end of the write phase
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            instr_ff <= 16'h0000;
            nop_ff   <= 1'b0;
        end else if (phase_ff == PH_WRITE) begin
            instr_ff <= I_INSTR;
            nop_ff   <= nop_next_ff;
        end
    end

    // Operand read: file byte, or the literal for literal forms
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            operand_ff <= 8'h00;
        end else if (phase_ff == PH_READ) begin
            if (is_or_l || is_call || is_bank_lo || is_bank_hi) begin
                operand_ff <= instr_ff[7:0];
            end else if (is_move && file_addr == ADDR_WORKING_REGISTER) begin
                // Working register lives here, not in the data space
                operand_ff <= working_register_ff;
            end else begin
                operand_ff <= I_RD_DATA;
            end
        end
    end

    // Processing stage
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            result_ff <= 9'h000;
        end else if (phase_ff == PH_PROCESS) begin
            if (is_inc || is_inc_sz || is_inc_snz) begin
                result_ff <= {1'b0, inc_in} + 9'h001;
            end else if (is_or_f || is_or_l) begin
                result_ff <= {1'b0, working_register_ff | operand_ff};
            end else begin
                result_ff <= {1'b0, operand_ff};
            end
        end
    end

    // Skip and call filler decision, made when the result is known
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            nop_next_ff <= 1'b0;
        end else if (phase_ff == PH_WRITE) begin
            nop_next_ff <= 1'b0;
        end else if (phase_ff == PH_PROCESS) begin
            // One decision point, so a call cannot mask a skip or vice versa
            nop_next_ff <= is_call
                           || (is_inc_sz && operand_ff == 8'hff)
                           || (is_inc_snz && operand_ff != 8'hff);
        end
    end

    // Working register and bank select writes
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            working_register_ff <= RST_WORKING_REGISTER;
            bank_ff <= RST_BANK;
        end else if (phase_ff == PH_WRITE) begin
            if ((is_inc || is_inc_sz || is_inc_snz || is_or_f) && !dest_file) begin
                working_register_ff <= res8;
            end else if (is_or_l) begin
                working_register_ff <= res8;
            end else if (is_move && instr_ff[12:8] == ADDR_WORKING_REGISTER[4:0]) begin
                working_register_ff <= res8;
            end
            if (is_bank_lo) begin
                bank_ff <= {bank_ff[7:4], res8[3:0]};
            end else if (is_bank_hi) begin
                bank_ff <= {res8[7:4], bank_ff[3:0]};
            end
        end
    end

    // Data space write strobe, one cycle in the write phase
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            wr_en_ff   <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_en_ff <= 1'b0;
            if (phase_ff == PH_PROCESS) begin
                wr_en_ff   <= ((is_inc || is_inc_sz || is_inc_snz || is_or_f) && dest_file)
                              || is_move;
                wr_addr_ff <= is_move ? {3'b000, instr_ff[12:8]} : file_addr;
                wr_data_ff <= (is_inc || is_inc_sz || is_inc_snz) ? operand_ff + 8'h01
                            : is_or_f ? (working_register_ff | operand_ff) : operand_ff;
            end
        end
    end

    // Flags: full set for plain increment, zero for OR forms
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            flags_ff <= 4'h0;
        end else if (phase_ff == PH_READ) begin
            flags_ff <= I_FLAGS;
        end else if (phase_ff == PH_WRITE) begin
            if (is_inc) begin
                flags_ff[FLAG_C]  <= result_ff[8];
                flags_ff[FLAG_DC] <= operand_ff[3:0] == 4'hf;
                flags_ff[FLAG_OV] <= operand_ff == 8'h7f;
                flags_ff[FLAG_Z]  <= res8 == 8'h00;
            end else if (is_or_f || is_or_l) begin
                flags_ff[FLAG_Z]  <= res8 == 8'h00;
            end
        end
    end

    // Program counter and return stack push
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pc_ff        <= RST_PC;
            push_ff      <= 1'b0;
            push_data_ff <= 16'h0000;
        end else begin
            push_ff <= 1'b0;
            if (phase_ff == PH_PROCESS && is_call) begin
                push_ff      <= 1'b1;
                push_data_ff <= pc_ff + 16'h0001;
            end
            if (phase_ff == PH_WRITE) begin
                if (is_call) begin
                    pc_ff <= {I_PC_LATCH, res8};
                end else begin
                    pc_ff <= pc_ff + 16'h0001;
                end
            end
        end
    end

    assign O_RD_ADDR   = file_addr;
    assign O_WR_EN     = wr_en_ff;
    assign O_WR_ADDR   = wr_addr_ff;
    assign O_WR_DATA   = wr_data_ff;
    assign O_PUSH_EN   = push_ff;
    assign O_PUSH_DATA = push_data_ff;
    assign O_FLAGS     = flags_ff;
    assign O_WORKING_REGISTER      = working_register_ff;
    assign O_BANK      = bank_ff;
    assign O_PC        = pc_ff;
    assign O_PHASE     = phase_ff;
    assign O_NOP_CYCLE = nop_ff;

    AST_BANK_HI_KEEPS_LOW: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_bank_hi) |=> bank_ff[3:0] == $past(bank_ff[3:0]))
        else $error("high nibble load changed low nibble");
    AST_BANK_LO_KEEPS_HIGH: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_bank_lo) |=> bank_ff == {$past(bank_ff[7:4]), $past(instr_ff[3:0])})
        else $error("low nibble load wrong");
    AST_CALL_PUSH: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_PROCESS && is_call) |=> O_PUSH_EN && O_PUSH_DATA == $past(pc_ff) + 16'h0001)
        else $error("call did not push return address");
    AST_CALL_TARGET: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_call) |=> pc_ff == {$past(I_PC_LATCH), $past(instr_ff[7:0])})
        else $error("call target wrong");
    AST_CALL_NOP: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_call) |=> nop_ff [*4])
        else $error("call missing filler cycle");
    AST_SKIP_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_inc_sz && res8 == 8'h00) |=> nop_ff)
        else $error("zero skip not taken");
    AST_SKIP_NZ: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_inc_snz && res8 != 8'h00) |=> nop_ff)
        else $error("nonzero skip not taken");
    AST_NOP_NO_WRITE: assert property (@(posedge I_CLK) disable iff (I_RST)
        nop_ff |-> !O_WR_EN && !O_PUSH_EN)
        else $error("filler cycle wrote");
    AST_OR_LIT: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_WRITE && is_or_l) |=> working_register_ff == ($past(working_register_ff) | $past(instr_ff[7:0])))
        else $error("literal OR wrong");
    AST_MOVE_ADDR: assert property (@(posedge I_CLK) disable iff (I_RST)
        (phase_ff == PH_PROCESS && is_move) |=> O_WR_EN && O_WR_ADDR == {3'b000, $past(instr_ff[12:8])})
        else $error("move wrote wrong address");
endmodule

//--- incexec_pkg.sv
// Package with opcode patterns, phases and reset values for the execute slice
package incexec_pkg;
    localparam logic [6:0] OPC_INC_FILE      = 7'h0a; // 0001 010
    localparam logic [6:0] OPC_INC_SKIP_Z    = 7'h0f; // 0001 111
    localparam logic [6:0] OPC_INC_SKIP_NZ   = 7'h12; // 0010 010
    localparam logic [6:0] OPC_OR_FILE       = 7'h04; // 0000 100
    localparam logic [7:0] OPC_OR_LITERAL    = 8'hb3;
    localparam logic [7:0] OPC_LONG_CALL     = 8'hb7;
    localparam logic [7:0] OPC_BANK_LOW      = 8'hb8;
    localparam logic [6:0] OPC_BANK_HIGH     = 7'h5d; // 1011 101
    localparam logic [2:0] OPC_MOVE_PERIPH   = 3'h3;  // 011
    localparam logic [7:0] ADDR_WORKING_REGISTER         = 8'h0a; // Working register in file/peripheral space
    localparam logic [7:0] RST_WORKING_REGISTER          = 8'h00;
    localparam logic [7:0] RST_BANK          = 8'h00;
    localparam logic [15:0] RST_PC           = 16'h0000;
    localparam int         FLAG_OV           = 3;
    localparam int         FLAG_Z            = 2;
    localparam int         FLAG_DC           = 1;
    localparam int         FLAG_C            = 0;
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
endpackage

//--- test_increment_or_move_call_exec.sv
// Self-checking bench for the increment, OR, call, move and bank-load slice
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_increment_or_move_call_exec
    import incexec_pkg::*;
;
    typedef struct packed {logic [15:0] w; logic [7:0] rd; logic [3:0] fl; logic [7:0] lat;} item_t;
    logic        clk, rst, o_wr_en, o_push_en, o_nop_cycle;
    logic [15:0] instr, o_push_data, o_pc, m_pc, e_pd;
    logic [7:0]  rd_data, pc_latch, o_rd_addr, o_wr_addr, o_wr_data, o_working_register, o_bank;
    logic [7:0]  m_working_register, m_bank, r, src, e_wa, e_wd, f;
    logic [3:0]  flags, o_flags, m_fl;
    logic [1:0]  ph, o_phase_w;
    logic [4:0]  b;
    logic        m_nop, no_operation, e_wr, e_push, chk_wr, live;
    item_t       q[$];
    item_t       cur;
    int          failures, check_count, seed, k;

    incexec_core dut (
        .I_CLK(clk), .I_RST(rst), .I_INSTR(instr), .O_RD_ADDR(o_rd_addr),
        .I_RD_DATA(rd_data), .O_WR_EN(o_wr_en), .O_WR_ADDR(o_wr_addr),
        .O_WR_DATA(o_wr_data), .O_PUSH_EN(o_push_en), .O_PUSH_DATA(o_push_data),
        .I_PC_LATCH(pc_latch), .I_FLAGS(flags), .O_FLAGS(o_flags), .O_WORKING_REGISTER(o_working_register),
        .O_BANK(o_bank), .O_PC(o_pc), .O_PHASE(o_phase_w), .O_NOP_CYCLE(o_nop_cycle)
    );

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    // Bench phase count, restarted by reset like the core's
    always @(posedge clk or posedge rst) begin
        if (rst) ph <= 2'h0;
        else ph <= ph + 2'h1;
    end

    task dest(input logic d, input logic [7:0] a, input logic [7:0] v);
        if (d) begin
            e_wr = 1;
            e_wa = a;
            e_wd = v;
        end else m_working_register = v;
    endtask

    // Reference model, run at the start of each executing cycle
    task model();
        no_operation = m_nop;
        m_nop = 0;
        e_wr = 0;
        e_push = 0;
        chk_wr = 1;
        // Flags pass through from the flag register every cycle, filler too
        m_fl = cur.fl;
        e_pd = m_pc + 16'h0001;
        m_pc = m_pc + 16'h0001;
        `CHK("nop_cycle", no_operation, o_nop_cycle)
        if (!no_operation) begin
            `CHK("rd_addr", cur.w[7:0], o_rd_addr)
            r = cur.rd + 8'h01;
            src = (cur.w[7:0] == 8'h0a) ? m_working_register : cur.rd;
            if (cur.w[15:13] == OPC_MOVE_PERIPH) begin
                // Peripheral 0x0a is the working register, no bus write checked
                chk_wr = cur.w[12:8] != 5'h0a;
                if (!chk_wr) m_working_register = src;
                else dest(1'b1, {3'h0, cur.w[12:8]}, src);
            end else if (cur.w[15:8] == OPC_OR_LITERAL) begin
                m_working_register = m_working_register | cur.w[7:0];
                m_fl[FLAG_Z] = m_working_register == 8'h00;
            end else if (cur.w[15:8] == OPC_LONG_CALL) begin
                e_push = 1;
                m_nop = 1;
                m_pc = {cur.lat, cur.w[7:0]};
            end else if (cur.w[15:8] == OPC_BANK_LOW) m_bank[3:0] = cur.w[3:0];
            else if (cur.w[15:9] == OPC_BANK_HIGH) m_bank[7:4] = cur.w[7:4];
            else if (cur.w[15:9] == OPC_OR_FILE) begin
                r = m_working_register | cur.rd;
                m_fl[FLAG_Z] = r == 8'h00;
                dest(cur.w[8], cur.w[7:0], r);
            end else begin
                dest(cur.w[8], cur.w[7:0], r);
                if (cur.w[15:9] == OPC_INC_FILE) begin
                    m_fl[FLAG_C] = cur.rd == 8'hff;
                    m_fl[FLAG_DC] = cur.rd[3:0] == 4'hf;
                    m_fl[FLAG_Z] = r == 8'h00;
                    m_fl[FLAG_OV] = cur.rd == 8'h7f;
                end
                if (cur.w[15:9] == OPC_INC_SKIP_Z) m_nop = r == 8'h00;
                if (cur.w[15:9] == OPC_INC_SKIP_NZ) m_nop = r != 8'h00;
            end
        end
    endtask

    always @(negedge clk) begin
        if (!rst) begin
            `CHK("phase", ph, o_phase_w)
            if (ph == 2'h0 && live) begin
                `CHK("working_register", m_working_register, o_working_register)
                `CHK("bank", m_bank, o_bank)
                `CHK("flags", m_fl, o_flags)
                `CHK("pc", m_pc, o_pc)
            end
            if (ph == 2'h0) begin
                live = q.size() != 0;
                if (live) cur = q.pop_front();
                if (live) model();
            end
            if (ph == 2'h3 && live && chk_wr) begin
                `CHK("wr_en", e_wr, o_wr_en)
                if (e_wr) `CHK("wr_addr", e_wa, o_wr_addr)
                if (e_wr) `CHK("wr_data", e_wd, o_wr_data)
                `CHK("push_en", e_push, o_push_en)
                if (e_push) `CHK("push_data", e_pd, o_push_data)
            end
        end
    end

    // Word goes out before the take edge, operands at it
    task step(input logic [15:0] w, input logic [7:0] rd);
        logic [3:0] fl;
        logic [7:0] lat;
        fl = 4'($random(seed));
        lat = 8'($random(seed));
        @(negedge clk);
        while (ph != 2'h2) @(negedge clk);
        @(posedge clk);
        instr <= w;
        q.push_back('{w, rd, fl, lat});
        @(posedge clk);
        rd_data <= rd;
        flags <= fl;
        pc_latch <= lat;
    endtask

    function automatic logic [15:0] mk(input int kd, input logic [7:0] a, input logic [4:0] p);
        case (kd)
            0: mk = {OPC_INC_FILE, p[0], a};
            1: mk = {OPC_INC_SKIP_Z, p[0], a};
            2: mk = {OPC_INC_SKIP_NZ, p[0], a};
            3: mk = {OPC_OR_FILE, p[0], a};
            4: mk = {OPC_OR_LITERAL, a};
            5: mk = {OPC_LONG_CALL, a};
            6: mk = {OPC_BANK_LOW, a};
            7: mk = {OPC_BANK_HIGH, p[0], a};
            default: mk = {OPC_MOVE_PERIPH, p, a};
        endcase
    endfunction

    task results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        seed = 80;
        failures = 0;
        check_count = 0;
        live = 0;
        m_nop = 0;
        {m_working_register, m_bank, m_pc} = {RST_WORKING_REGISTER, RST_BANK, RST_PC};
        {rst, instr, rd_data, flags, pc_latch} = {1'b1, 36'h0};
        repeat (16) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        `CHK("reset", {RST_WORKING_REGISTER, RST_BANK, RST_PC}, {o_working_register, o_bank, o_pc})
        // One write edge passes before the first word executes
        m_pc = RST_PC + 16'h0001;
        step(mk(0, 8'h20, 5'h1), 8'hff);
        step(mk(0, 8'h21, 5'h0), 8'h7f);
        step(mk(1, 8'h22, 5'h0), 8'hff);
        step(mk(6, 8'h57, 5'h0), 8'h00);
        step(mk(1, 8'h23, 5'h1), 8'h05);
        step(mk(2, 8'h24, 5'h1), 8'h05);
        step(mk(7, 8'hf0, 5'h0), 8'h00);
        step(mk(2, 8'h25, 5'h0), 8'hff);
        step(mk(3, 8'h30, 5'h0), 8'h00);
        step(mk(4, 8'h35, 5'h0), 8'h00);
        step(mk(3, 8'hff, 5'h1), 8'h91);
        step(mk(5, 8'hc4, 5'h0), 8'h00);
        step(mk(6, 8'h53, 5'h0), 8'h00);
        step(mk(8, 8'h40, 5'h1f), 8'h33);
        step(mk(8, 8'h00, 5'h00), 8'h5a);
        step(mk(8, 8'h42, 5'h0a), 8'hc3);
        step(mk(8, 8'h0a, 5'h05), 8'h00);
        step(mk(6, 8'ha5, 5'h0), 8'h00);
        step(mk(7, 8'h3c, 5'h1), 8'h00);
        for (int i = 0; i < 60; i++) begin
            k = {$random(seed)} % 9;
            f = 8'($random(seed));
            b = 5'($random(seed));
            if (k < 4 && f == 8'h0a) f = 8'h0b;
            step(mk(k, f, b), 8'($random(seed)));
        end
        repeat (12) @(posedge clk);
        results();
    end

    // Run needs about 350 clocks; this is a generous ceiling
    initial begin
        #(40 * 2000);
        failures++;
        results();
    end
endmodule
